/* File: src/rhsc_root_hub_status.sv */
// Root hub status and control register with overcurrent, wakeup, global power and interrupts.
`timescale 1ns/1ps
`include "rhsc_map.svh"
module rhsc_root_hub_status #(
  parameter int NPORTS = 2
) (
  input  wire logic                 CLK_I,
  input  wire logic                 RST_I,
  input  wire rhsc_pkg::rhsc_addr_t ADDR_I,
  input  wire rhsc_pkg::rhsc_word_t WDATA_I,
  input  wire logic                 WR_I,
  input  wire logic                 RD_I,
  output rhsc_pkg::rhsc_word_t      RDATA_O,
  input  wire logic                 OVERCURRENT_PIN_I,
  input  wire logic                 PER_PORT_OC_I,
  input  wire logic                 PER_PORT_SWITCHING_SELECT_I,
  input  wire logic [NPORTS:1]      PORT_POWER_MASK_I,
  input  wire logic [NPORTS:1]      PORT_ON_I,
  input  wire logic [NPORTS:1]      PORT_OFF_I,
  input  wire logic                 ATTACH_CHANGE_FLAG_I,
  input  wire logic                 SUSPEND_REQ_I,
  input  wire logic                 RESUME_DONE_I,
  output logic [NPORTS:1]           PORT_POWERED_FLAG_O,
  output logic                      HOST_SUSPENDED_STATE_O,
  output logic                      HOST_RESUMING_STATE_O,
  output logic                      RESUME_SEEN_INTERRUPT_O,
  output logic                      IRQ_O
);
  import rhsc_pkg::*;

  localparam int NIRQ = 3;

  logic             oc_sync;
  logic             oc_prev_reg;
  logic             global_overcurrent_indicator;
  logic             overcurrent_change_flag_reg;
  logic             remote_wakeup_enable_flag_reg;
  logic             wr_hub;
  logic             power_on_all;
  logic             power_off_all;
  logic             oc_event;
  logic             resume_event;
  rhsc_host_e       host_reg;
  logic [NIRQ-1:0]  irq_status_reg;
  logic [NIRQ-1:0]  irq_enable_reg;
  logic [NIRQ-1:0]  irq_set;
  logic [NIRQ-1:0]  irq_clear;
  rhsc_word_t       hub_word;
  rhsc_word_t       rdata_next;

  // Returns one when a write of the given bit position carries a one.
  function automatic logic wr_bit(input logic wr, input rhsc_word_t data, input int pos);
    wr_bit = wr && data[pos];
  endfunction : wr_bit

  // The overcurrent pin is asynchronous, so it passes two flip-flops first.
  rhsc_sync #(
    .WIDTH (1)
  ) u_oc_sync (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .async_i (OVERCURRENT_PIN_I),
    .sync_o  (oc_sync)
  );

  assign wr_hub = WR_I && (ADDR_I == `RHSC_CMD_WRITE);

  assign global_overcurrent_indicator = oc_sync && !PER_PORT_OC_I;

  // Edge history of the indicator, used for the change flag.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      oc_prev_reg <= 1'b0;
    end else begin
      oc_prev_reg <= global_overcurrent_indicator;
    end
  end

  assign oc_event = global_overcurrent_indicator != oc_prev_reg;

  // Change flag; a change in the clearing cycle wins so no event is lost.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      overcurrent_change_flag_reg <= 1'b0;
    end else if (oc_event) begin
      overcurrent_change_flag_reg <= 1'b1;
    end else if (wr_bit(wr_hub, WDATA_I, `RHSC_BIT_OC_CHANGE)) begin
      overcurrent_change_flag_reg <= 1'b0;
    end
  end

  // Wakeup enable; set and clear in one write leaves it cleared, the safer outcome.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      remote_wakeup_enable_flag_reg <= 1'b0;
    end else if (wr_bit(wr_hub, WDATA_I, `RHSC_BIT_CLR_WAKE)) begin
      remote_wakeup_enable_flag_reg <= 1'b0;
    end else if (wr_bit(wr_hub, WDATA_I, `RHSC_BIT_WAKE)) begin
      remote_wakeup_enable_flag_reg <= 1'b1;
    end
  end

  assign power_on_all  = wr_bit(wr_hub, WDATA_I, `RHSC_BIT_POWER_ON);
  assign power_off_all = wr_bit(wr_hub, WDATA_I, `RHSC_BIT_POWER_OFF);

  // Port power state with mask filtering.
  rhsc_port_power #(
    .NPORTS (NPORTS)
  ) u_port_power (
    .clk_i                       (CLK_I),
    .rst_i                       (RST_I),
    .per_port_switching_select_i (PER_PORT_SWITCHING_SELECT_I),
    .port_power_mask_i           (PORT_POWER_MASK_I),
    .global_on_i                 (power_on_all),
    .global_off_i                (power_off_all),
    .port_on_i                   (PORT_ON_I),
    .port_off_i                  (PORT_OFF_I),
    .port_powered_flag_o         (PORT_POWERED_FLAG_O)
  );

  assign resume_event = ATTACH_CHANGE_FLAG_I && remote_wakeup_enable_flag_reg && (host_reg == RHSC_SUSPENDED);

  // Host power state; the attach change input is same-clock logic and takes no synchroniser.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      host_reg <= RHSC_RUNNING;
    end else begin
      unique case (host_reg)
        RHSC_RUNNING: begin
          if (SUSPEND_REQ_I) begin
            host_reg <= RHSC_SUSPENDED;
          end
        end
        RHSC_SUSPENDED: begin
          if (resume_event) begin
            host_reg <= RHSC_RESUMING;
          end
        end
        RHSC_RESUMING: begin
          if (RESUME_DONE_I) begin
            host_reg <= RHSC_RUNNING;
          end
        end
      endcase
    end
  end

  assign HOST_SUSPENDED_STATE_O = host_reg == RHSC_SUSPENDED;
  assign HOST_RESUMING_STATE_O  = host_reg == RHSC_RESUMING;

  // Interrupt sources: overcurrent change, resume, and raw attach while wakeup is on.
  always_comb begin
    irq_set = '0;
    irq_set[`RHSC_IRQ_OC_CHANGE]  = oc_event;
    irq_set[`RHSC_IRQ_RESUME]     = resume_event;
    irq_set[`RHSC_IRQ_RESUME_RAW] = ATTACH_CHANGE_FLAG_I && remote_wakeup_enable_flag_reg;
  end

  assign irq_clear = (WR_I && ADDR_I == `RHSC_IRQ_CLEAR_ADR) ? WDATA_I[NIRQ-1:0] : '0;

  // Sticky status; a new event outranks a clear in the same cycle.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= irq_set | (irq_status_reg & ~irq_clear);
    end
  end

  // Enable register written by software.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      irq_enable_reg <= '0;
    end else if (WR_I && ADDR_I == `RHSC_IRQ_ENABLE_ADR) begin
      irq_enable_reg <= WDATA_I[NIRQ-1:0];
    end
  end

  assign IRQ_O                   = |(irq_status_reg & irq_enable_reg);
  assign RESUME_SEEN_INTERRUPT_O = irq_status_reg[`RHSC_IRQ_RESUME];

  always_comb begin
    hub_word = `RHSC_RESET_WORD;
    hub_word[`RHSC_BIT_OCI]       = global_overcurrent_indicator;
    hub_word[`RHSC_BIT_WAKE]      = remote_wakeup_enable_flag_reg;
    hub_word[`RHSC_BIT_OC_CHANGE] = overcurrent_change_flag_reg;
  end

  // Read mux; unmapped addresses return zero.
  always_comb begin
    rdata_next = '0;
    unique case (ADDR_I)
      `RHSC_CMD_READ:       rdata_next = hub_word;
      `RHSC_IRQ_STATUS_ADR: rdata_next[NIRQ-1:0] = irq_status_reg;
      `RHSC_IRQ_ENABLE_ADR: rdata_next[NIRQ-1:0] = irq_enable_reg;
      `RHSC_CTRL_ADR:       rdata_next[1:0] = {PER_PORT_OC_I, PER_PORT_SWITCHING_SELECT_I};
      `RHSC_PORT_ADR:       rdata_next[NPORTS:1] = PORT_POWERED_FLAG_O;
      default:              rdata_next = '0;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      RDATA_O <= '0;
    end else if (RD_I) begin
      RDATA_O <= rdata_next;
    end else begin
      RDATA_O <= '0;
    end
  end
endmodule : rhsc_root_hub_status

/* File: src/rhsc_map.svh */
// Register offsets, field positions, reset values and command codes of the root hub status block.
`ifndef RHSC_MAP_SVH
`define RHSC_MAP_SVH
`define RHSC_CMD_READ        8'h14
`define RHSC_CMD_WRITE       8'h94
`define RHSC_IRQ_STATUS_ADR  8'h20
`define RHSC_IRQ_CLEAR_ADR   8'h21
`define RHSC_IRQ_ENABLE_ADR  8'h22
`define RHSC_CTRL_ADR        8'h23
`define RHSC_PORT_ADR        8'h24
`define RHSC_BIT_POWER_OFF   0
`define RHSC_BIT_OCI         1
`define RHSC_BIT_WAKE        15
`define RHSC_BIT_POWER_ON    16
`define RHSC_BIT_OC_CHANGE   17
`define RHSC_BIT_CLR_WAKE    31
`define RHSC_IRQ_OC_CHANGE   0
`define RHSC_IRQ_RESUME      1
`define RHSC_IRQ_RESUME_RAW  2
`define RHSC_RESET_WORD      32'h00000000
`endif

/* File: src/rhsc_pkg.sv */
// Types shared by the root hub status block.
package rhsc_pkg;
  typedef logic [7:0]  rhsc_addr_t;
  typedef logic [31:0] rhsc_word_t;
  typedef enum logic [1:0] {
    RHSC_RUNNING,
    RHSC_SUSPENDED,
    RHSC_RESUMING
  } rhsc_host_e;
endpackage : rhsc_pkg

/* File: src/rhsc_sync.sv */
// Two flip-flop synchroniser for a vector of pin levels.
`timescale 1ns/1ps
module rhsc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule : rhsc_sync

/* File: src/rhsc_port_power.sv */
// Per-port power state with global set and clear actions filtered by the port power mask while per-port switching is selected.
`timescale 1ns/1ps
module rhsc_port_power #(
  parameter int NPORTS = 2
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              per_port_switching_select_i,
  input  wire logic [NPORTS:1]   port_power_mask_i,
  input  wire logic              global_on_i,
  input  wire logic              global_off_i,
  input  wire logic [NPORTS:1]   port_on_i,
  input  wire logic [NPORTS:1]   port_off_i,
  output logic      [NPORTS:1]   port_powered_flag_o
);
  genvar g;
  generate
    for (g = 1; g <= NPORTS; g++) begin : g_port
      logic follows_global;
      assign follows_global = !per_port_switching_select_i || !port_power_mask_i[g];

      // Global actions move only ports that follow them; masked ports take per-port commands only while per-port switching is selected.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          port_powered_flag_o[g] <= 1'b0;
        end else if (global_on_i && follows_global) begin
          port_powered_flag_o[g] <= 1'b1;
        end else if (global_off_i && follows_global) begin
          port_powered_flag_o[g] <= 1'b0;
        end else if (port_on_i[g] && per_port_switching_select_i && port_power_mask_i[g]) begin
          port_powered_flag_o[g] <= 1'b1;
        end else if (port_off_i[g] && per_port_switching_select_i && port_power_mask_i[g]) begin
          port_powered_flag_o[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule : rhsc_port_power

/* File: sim/rhsc_root_hub_status_checker.sv */
// Port-level checks of the root hub status block.
`timescale 1ns/1ps
module rhsc_root_hub_status_checker #(
  parameter int NPORTS = 2
) (
  input wire logic                 CLK_I,
  input wire logic                 RST_I,
  input wire rhsc_pkg::rhsc_addr_t ADDR_I,
  input wire rhsc_pkg::rhsc_word_t WDATA_I,
  input wire logic                 WR_I,
  input wire logic                 RD_I,
  input wire rhsc_pkg::rhsc_word_t RDATA_O,
  input wire logic                 PER_PORT_OC_I,
  input wire logic                 PER_PORT_SWITCHING_SELECT_I,
  input wire logic [NPORTS:1]      PORT_POWER_MASK_I,
  input wire logic [NPORTS:1]      PORT_POWERED_FLAG_O,
  input wire logic                 HOST_RESUMING_STATE_O,
  input wire logic                 RESUME_SEEN_INTERRUPT_O
);
  import rhsc_pkg::*;
  // All checks share the one clock and its reset.
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  chk_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
    else $error("read data not idle");
  chk_local_zero: assert property ($past(RD_I) && $past(ADDR_I) == 8'h14 |-> !RDATA_O[0] && !RDATA_O[16])
    else $error("local power bits not zero");
  chk_layout_bits: assert property ($past(RD_I) && $past(ADDR_I) == 8'h14 |-> (RDATA_O & 32'hFFFD7FFD) == 32'h0)
    else $error("reserved hub bit set");
  chk_global_on: assert property (WR_I && ADDR_I == 8'h94 && WDATA_I[16] && !PER_PORT_SWITCHING_SELECT_I
    |=> PORT_POWERED_FLAG_O == {NPORTS{1'b1}}) else $error("global on missed");
  chk_global_off: assert property (WR_I && ADDR_I == 8'h94 && WDATA_I[0] && !WDATA_I[16]
    && !PER_PORT_SWITCHING_SELECT_I |=> PORT_POWERED_FLAG_O == '0) else $error("global off missed");
  chk_unmasked_on: assert property (WR_I && ADDR_I == 8'h94 && WDATA_I[16] && PER_PORT_SWITCHING_SELECT_I
    |=> (PORT_POWERED_FLAG_O | $past(PORT_POWER_MASK_I)) == {NPORTS{1'b1}}) else $error("unmasked on missed");
  chk_unmasked_off: assert property (WR_I && ADDR_I == 8'h94 && WDATA_I[0] && !WDATA_I[16]
    && PER_PORT_SWITCHING_SELECT_I |=> (PORT_POWERED_FLAG_O & ~$past(PORT_POWER_MASK_I)) == '0)
    else $error("unmasked off missed");
  chk_oc_forced: assert property ($past(RD_I) && $past(ADDR_I) == 8'h14 && $past(PER_PORT_OC_I)
    && $past(PER_PORT_OC_I, 2) && $past(PER_PORT_OC_I, 3) |-> !RDATA_O[1]) else $error("indicator not forced");
  chk_resume_irq: assert property ($rose(HOST_RESUMING_STATE_O) |-> RESUME_SEEN_INTERRUPT_O)
    else $error("resume without interrupt");
endmodule : rhsc_root_hub_status_checker

bind rhsc_root_hub_status rhsc_root_hub_status_checker #(.NPORTS(NPORTS)) u_chk (
  .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .PER_PORT_OC_I(PER_PORT_OC_I), .PER_PORT_SWITCHING_SELECT_I(PER_PORT_SWITCHING_SELECT_I),
  .PORT_POWER_MASK_I(PORT_POWER_MASK_I), .PORT_POWERED_FLAG_O(PORT_POWERED_FLAG_O),
  .HOST_RESUMING_STATE_O(HOST_RESUMING_STATE_O), .RESUME_SEEN_INTERRUPT_O(RESUME_SEEN_INTERRUPT_O));

/* File: sim/tb_top.sv */
// Self-checking bench for the root hub status block.
`timescale 1ns/1ps
module tb_top;
  import rhsc_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ocp = 1'b0, ppoc = 1'b0, sel = 1'b0;
  logic       att = 1'b0, susp = 1'b0, rdone = 1'b0, s_st, r_st, rsi, irq;
  logic [2:1] mask = 2'h0, pon = 2'h0, poff = 2'h0, pwr;
  rhsc_addr_t addr = 8'h00;
  rhsc_word_t wdata = 32'h0, rdata;
  int         n_mismatch = 0, samples_checked = 0;
  // Clock of 40 ns period.
  always #20 clk = ~clk;
  rhsc_root_hub_status #(.NPORTS(2)) DUT (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .OVERCURRENT_PIN_I(ocp), .PER_PORT_OC_I(ppoc),
    .PER_PORT_SWITCHING_SELECT_I(sel), .PORT_POWER_MASK_I(mask), .PORT_ON_I(pon), .PORT_OFF_I(poff),
    .ATTACH_CHANGE_FLAG_I(att), .SUSPEND_REQ_I(susp), .RESUME_DONE_I(rdone), .PORT_POWERED_FLAG_O(pwr),
    .HOST_SUSPENDED_STATE_O(s_st), .HOST_RESUMING_STATE_O(r_st), .RESUME_SEEN_INTERRUPT_O(rsi), .IRQ_O(irq));
  // Compare and count; four-state equality lets no unknown slip through.
  task chk(input rhsc_word_t got, input rhsc_word_t exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task bus_wr(input rhsc_addr_t a, input rhsc_word_t d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
    #1;
  endtask : bus_wr
  // Read data stand only in the cycle after the strobe.
  task bus_rd(input rhsc_addr_t a, input rhsc_word_t exp, input rhsc_word_t m);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata & m, exp);
  endtask : bus_rd
  task end_sim;
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // Watchdog well beyond the hundred or so cycles the tests need.
  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus_rd(8'h14, 32'h0, 32'hFFFFFFFF);
    bus_wr(8'h94, 32'h00008000);
    bus_rd(8'h14, 32'h00008000, 32'hFFFFFFFF);
    bus_wr(8'h94, 32'h80000000);
    bus_rd(8'h14, 32'h0, 32'hFFFFFFFF);
    bus_wr(8'h94, 32'h00010000); chk({30'h0, pwr}, 32'h3);
    bus_wr(8'h94, 32'h00000001); chk({30'h0, pwr}, 32'h0);
    @(posedge clk) begin sel <= 1'b1; mask <= 2'h2; end
    bus_wr(8'h94, 32'h00010000); chk({30'h0, pwr}, 32'h1);
    @(posedge clk) pon <= 2'b10;
    @(posedge clk) pon <= 2'b00;
    #1 chk({30'h0, pwr}, 32'h3);
    bus_wr(8'h94, 32'h00000001); chk({30'h0, pwr}, 32'h2);
    // A per-port command on an unmasked port must be ignored; on a masked port it acts.
    @(posedge clk) pon <= 2'h1;
    @(posedge clk) pon <= 2'h0;
    #1 chk({30'h0, pwr}, 32'h2);
    @(posedge clk) poff <= 2'h2;
    @(posedge clk) poff <= 2'h0;
    #1 chk({30'h0, pwr}, 32'h0);
    bus_rd(8'h14, 32'h0, 32'h00010001);
    bus_wr(8'h22, 32'h1);
    @(posedge clk) ocp <= 1'b1;
    repeat (5) @(posedge clk);
    bus_rd(8'h14, 32'h00020002, 32'hFFFFFFFF);
    chk({31'h0, irq}, 32'h1);
    bus_wr(8'h94, 32'h00020000);
    bus_rd(8'h14, 32'h00000002, 32'hFFFFFFFF);
    bus_wr(8'h21, 32'h1); chk({31'h0, irq}, 32'h0);
    @(posedge clk) ppoc <= 1'b1;
    repeat (5) @(posedge clk);
    bus_rd(8'h14, 32'h0, 32'h2);
    bus_wr(8'h30, 32'hFFFFFFFF);
    bus_rd(8'h30, 32'h0, 32'hFFFFFFFF);
    // One write carrying power on, power off, wakeup set and change clear; reserved bits stay zero.
    bus_wr(8'h94, 32'h00038001);
    chk({30'h0, pwr}, 32'h1);
    bus_rd(8'h14, 32'h00008000, 32'hFFFFFFFF);
    bus_wr(8'h94, 32'h80000000);
    // Attach while wakeup is disabled must leave the host suspended.
    @(posedge clk) susp <= 1'b1;
    @(posedge clk) susp <= 1'b0;
    @(posedge clk) att <= 1'b1;
    @(posedge clk) att <= 1'b0;
    @(posedge clk);
    #1 chk({30'h0, s_st, r_st}, 32'h2);
    bus_wr(8'h94, 32'h00008000);
    @(posedge clk) att <= 1'b1;
    @(posedge clk) att <= 1'b0;
    @(posedge clk);
    #1 chk({30'h0, r_st, rsi}, 32'h3);
    bus_rd(8'h20, 32'h7, 32'hFFFFFFFF);
    bus_rd(8'h22, 32'h1, 32'hFFFFFFFF);
    bus_rd(8'h23, 32'h3, 32'hFFFFFFFF);
    bus_rd(8'h24, 32'h2, 32'hFFFFFFFF);
    chk({31'h0, irq}, 32'h1);
    // Resume completion returns the host to the running state.
    @(posedge clk) rdone <= 1'b1;
    @(posedge clk) rdone <= 1'b0;
    #1 chk({30'h0, s_st, r_st}, 32'h0);
    end_sim();
  end
endmodule : tb_top
